//--- rtl/battery_monitor_adc_sequencer.sv
// Converter sequencing, power-switch watch and powered duties
`timescale 1ns/1ps
module battery_monitor_adc_sequencer #(
    parameter int unsigned CHECK_CYC = adc_seq_pkg::CHECK_CYC,
    parameter int unsigned POWER_CYC = adc_seq_pkg::POWER_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // External pins
    input wire logic power_switch,
    input wire logic shutdown_req,
    input wire logic analog_trigger,
    input wire logic adc_sdi,
    input wire logic ga_sdata,
    input wire logic [7:0] key_return_lines,
    // Converter pins
    output adc_seq_pkg::adc_pins_t adc_pins,
    // Keyboard pins
    output logic [8:0] key_scan_lines,
    output logic switch_scan_line,
    // System status
    output logic system_on,
    output logic power_on_req,
    output logic batt_backup,
    output logic low_volt_irq,
    // Results
    output logic [7:0] battery_value,
    output logic [7:0] analog_value,
    output logic analog_valid,
    output logic [7:0] ga_command,
    output logic [6:0] dip_switches,
    output logic key_event,
    output logic [3:0] key_line,
    output logic [7:0] key_bits
);
    adc_seq_pkg::pin_in_t pins, sync1_q, sync2_q;
    logic sw_prev_q, trig_prev_q, shut1_q, shut2_q;
    adc_seq_pkg::seq_state_t st_q, st_d;
    logic [31:0] per_q, per_d, win_q, win_d, wait_q, wait_d;
    logic pwr_q, pwr_d, mode_q, mode_d, on_q, on_d, req_q, req_d;
    logic bk_q, bk_d, irq_q, irq_d, av_q, av_d, analog_job_q, analog_job_d, init_q;
    logic [7:0] bv_q, bv_d, anv_q, anv_d, cmd_q, cmd_d, tx;
    logic sh_start, sh_busy, sh_done, sh_sck, sh_sdo, sh_sdi;
    logic [7:0] sh_rx;
    logic sw_change, trig_rise, period_end;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    assign pins = '{power_switch, analog_trigger, adc_sdi, ga_sdata, key_return_lines};

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sync1_q <= '0;
            sync2_q <= '0;
            shut1_q <= 1'b0;
            shut2_q <= 1'b0;
            sw_prev_q <= 1'b0;
            trig_prev_q <= 1'b0;
            init_q <= 1'b0;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
            shut1_q <= shutdown_req;
            shut2_q <= shut1_q;
            sw_prev_q <= sync2_q.power_switch;
            trig_prev_q <= sync2_q.analog_trigger;
            init_q <= on_d && !on_q;
        end
    end

    assign sw_change = sync2_q.power_switch != sw_prev_q;
    assign trig_rise = sync2_q.analog_trigger && !trig_prev_q;
    assign period_end = (per_q == CHECK_CYC - 1);

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        per_d = period_end ? 32'h0000_0000 : per_q + 32'h0000_0001;
        win_d = pwr_q ? win_q + 32'h0000_0001 : 32'h0000_0000;
        wait_d = wait_q + 32'h0000_0001;
        pwr_d = pwr_q;
        mode_d = mode_q;
        on_d = on_q;
        req_d = 1'b0;
        bk_d = bk_q;
        irq_d = irq_q;
        av_d = 1'b0;
        analog_job_d = analog_job_q;
        bv_d = bv_q;
        anv_d = anv_q;
        cmd_d = cmd_q;
        sh_start = 1'b0;
        tx = analog_job_q ? adc_seq_pkg::ANALOG_IN_CHANNEL
                          : adc_seq_pkg::BATTERY_SENSE_CHANNEL;
        if (!on_q && sw_change) begin
            on_d = 1'b1;
            req_d = 1'b1;
        end else if (on_q && shut2_q) begin
            on_d = 1'b0;
        end
        if (!on_q) begin
            irq_d = 1'b0;
        end
        case (st_q)
            adc_seq_pkg::ST_IDLE: begin
                mode_d = 1'b1;
                if (period_end || (on_q && trig_rise)) begin
                    analog_job_d = !period_end;
                    pwr_d = 1'b1;
                    wait_d = 32'h0000_0000;
                    st_d = adc_seq_pkg::ST_SETTLE;
                end
            end
            adc_seq_pkg::ST_SETTLE: begin
                if (wait_q == adc_seq_pkg::SETTLE_CYC - 1) begin
                    sh_start = 1'b1;
                    st_d = on_q ? adc_seq_pkg::ST_FETCH : adc_seq_pkg::ST_SELECT;
                    // interface mode first; stays high over a gate array fetch
                    mode_d = on_q;
                    if (!on_q) begin
                        sh_start = 1'b0;
                    end
                end
            end
            adc_seq_pkg::ST_FETCH: begin
                if (sh_done) begin
                    cmd_d = sh_rx;
                    mode_d = 1'b0;
                    st_d = adc_seq_pkg::ST_SELECT;
                end
            end
            adc_seq_pkg::ST_SELECT: begin
                sh_start = !sh_busy && !sh_done && !mode_q;
                mode_d = 1'b0;
                if (sh_done) begin
                    mode_d = 1'b1;
                    wait_d = 32'h0000_0000;
                    st_d = adc_seq_pkg::ST_CONVERT;
                end
            end
            adc_seq_pkg::ST_CONVERT: begin
                if (wait_q == adc_seq_pkg::CONV_CYC - 1) begin
                    mode_d = 1'b0;
                    st_d = adc_seq_pkg::ST_READ;
                end
            end
            adc_seq_pkg::ST_READ: begin
                sh_start = !sh_busy && !sh_done && !mode_q;
                if (sh_done) begin
                    mode_d = 1'b1;
                    st_d = adc_seq_pkg::ST_HOLD;
                    if (analog_job_q) begin
                        anv_d = sh_rx;
                        av_d = 1'b1;
                    end else begin
                        bv_d = sh_rx;
                        bk_d = sh_rx < adc_seq_pkg::BATT_LOW_THRESHOLD;
                        irq_d = on_q && (sh_rx < adc_seq_pkg::BATT_LOW_THRESHOLD);
                    end
                end
            end
            adc_seq_pkg::ST_HOLD: begin
                // Supply stays up for the whole window so timing is fixed
                if (win_q >= POWER_CYC - 1) begin
                    pwr_d = 1'b0;
                    st_d = adc_seq_pkg::ST_IDLE;
                end
            end
            default: begin
                st_d = adc_seq_pkg::ST_IDLE;
                pwr_d = 1'b0;
            end
        endcase
        if (pwr_q && win_q >= POWER_CYC - 1) begin
            pwr_d = 1'b0;
            mode_d = 1'b1;
            st_d = adc_seq_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            st_q <= adc_seq_pkg::ST_IDLE;
            per_q <= 32'h0000_0000;
            win_q <= 32'h0000_0000;
            wait_q <= 32'h0000_0000;
            pwr_q <= 1'b0;
            mode_q <= 1'b1;
            on_q <= 1'b0;
            req_q <= 1'b0;
            bk_q <= 1'b0;
            irq_q <= 1'b0;
            av_q <= 1'b0;
            analog_job_q <= 1'b0;
            bv_q <= 8'h00;
            anv_q <= 8'h00;
            cmd_q <= 8'h00;
        end else begin
            st_q <= st_d;
            per_q <= per_d;
            win_q <= win_d;
            wait_q <= wait_d;
            pwr_q <= pwr_d;
            mode_q <= mode_d;
            on_q <= on_d;
            req_q <= req_d;
            bk_q <= bk_d;
            irq_q <= irq_d;
            av_q <= av_d;
            analog_job_q <= analog_job_d;
            bv_q <= bv_d;
            anv_q <= anv_d;
            cmd_q <= cmd_d;
        end
    end

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    assign sh_sdi = (st_q == adc_seq_pkg::ST_FETCH) ? sync2_q.ga_sdata : sync2_q.adc_sdi;

    serial_shifter u_shift (
        .clk(clk),
        .reset_n(reset_n),
        .start(sh_start),
        .tx_byte(tx),
        .sdi(sh_sdi),
        .busy(sh_busy),
        .done(sh_done),
        .rx_byte(sh_rx),
        .sck(sh_sck),
        .sdo(sh_sdo)
    );

    key_scanner u_keys (
        .clk(clk),
        .reset_n(reset_n),
        .enable(on_q),
        .init(init_q),
        .key_return_lines(sync2_q.key_return_lines),
        .key_scan_lines(key_scan_lines),
        .switch_scan_line(switch_scan_line),
        .dip_switches(dip_switches),
        .key_event(key_event),
        .key_line(key_line),
        .key_bits(key_bits)
    );

    assign adc_pins = '{pwr_q, mode_q, sh_sck, sh_sdo};
    assign system_on = on_q;
    assign power_on_req = req_q;
    assign batt_backup = bk_q;
    assign low_volt_irq = irq_q;
    assign battery_value = bv_q;
    assign analog_value = anv_q;
    assign analog_valid = av_q;
    assign ga_command = cmd_q;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_select_done;
        (st_q == adc_seq_pkg::ST_SELECT) && sh_done;
    endsequence

    property p_window_len;
        @(posedge clk) disable iff (!reset_n)
            $fell(pwr_q) |-> ($past(win_q) == POWER_CYC - 1);
    endproperty
    a_window_len: assert property (p_window_len)
        else $error("converter supply window has wrong length");

    property p_mode_low_select;
        @(posedge clk) disable iff (!reset_n)
            ((st_q == adc_seq_pkg::ST_SELECT) && sh_busy) |-> !mode_q;
    endproperty
    a_mode_low_select: assert property (p_mode_low_select)
        else $error("channel byte sent outside interface mode");

    property p_mode_rise;
        @(posedge clk) disable iff (!reset_n)
            s_select_done |=> mode_q && (st_q == adc_seq_pkg::ST_CONVERT);
    endproperty
    a_mode_rise: assert property (p_mode_rise)
        else $error("mode did not rise after channel byte");

    property p_mode_low_read;
        @(posedge clk) disable iff (!reset_n)
            ((st_q == adc_seq_pkg::ST_READ) && sh_busy) |-> !mode_q && pwr_q;
    endproperty
    a_mode_low_read: assert property (p_mode_low_read)
        else $error("result read outside interface mode");

    property p_backup;
        @(posedge clk) disable iff (!reset_n)
            ((st_q == adc_seq_pkg::ST_READ) && sh_done && !analog_job_q)
            |=> (bk_q == ($past(sh_rx) < adc_seq_pkg::BATT_LOW_THRESHOLD));
    endproperty
    a_backup: assert property (p_backup)
        else $error("backup output disagrees with battery value");

    property p_wake;
        @(posedge clk) disable iff (!reset_n)
            (!on_q && sw_change) |=> on_q && req_q ##1 !req_q;
    endproperty
    a_wake: assert property (p_wake)
        else $error("switch change did not wake system");

    property p_irq_off;
        @(posedge clk) disable iff (!reset_n) !on_q |=> !irq_q;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("low-voltage interrupt raised while off");

    property p_order;
        @(posedge clk) disable iff (!reset_n)
            ((st_q == adc_seq_pkg::ST_FETCH) && sh_done)
            |=> (st_q == adc_seq_pkg::ST_SELECT) ##[1:3] sh_busy;
    endproperty
    a_order: assert property (p_order)
        else $error("burst steps out of order");

    property p_trigger;
        @(posedge clk) disable iff (!reset_n)
            (on_q && trig_rise && (st_q == adc_seq_pkg::ST_IDLE) && !period_end)
            |=> pwr_q && analog_job_q;
    endproperty
    a_trigger: assert property (p_trigger)
        else $error("analog trigger ignored");

endmodule : battery_monitor_adc_sequencer

//--- rtl/adc_seq_pkg.sv
// Constants, types and states shared by the battery monitor sequencer
//
// Functional notes
// - While off, power converter every 10 s for about 7.5 ms.
// - Mode output low puts converter in interface mode before serial traffic.
// - Shift out one channel byte with eight shift clocks selecting battery sense.
// - After channel byte, mode output goes high to start conversion.
// - After conversion, mode low again and shift clocks read result bitwise.
// - Battery value below threshold asserts backup control output.
// - While off, any power switch change is a power-on request.
// - While powered, scan nine key scan lines and read eight return lines.
// - At initialization, drive switch scan line and read seven return lines.
// - While powered, raise low-voltage interrupt and keep auxiliary backup.
// - While powered, analog trigger runs converter and reads analog value.
// - Burst order: fetch gate array command (only while powered), select channel, read data.
package adc_seq_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 50;
    localparam int unsigned CHECK_PERIOD_S = 10;
    localparam int unsigned CHECK_CYC = CHECK_PERIOD_S * CLK_MHZ * 1000000;
    localparam int unsigned POWER_WINDOW_US = 7500;
    localparam int unsigned POWER_CYC = POWER_WINDOW_US * CLK_MHZ;
    localparam int unsigned SCK_HALF_NS = 1000;
    localparam int unsigned SCK_HALF_CYC = SCK_HALF_NS * CLK_MHZ / 1000;
    localparam int unsigned SETTLE_US = 50;
    localparam int unsigned SETTLE_CYC = SETTLE_US * CLK_MHZ;
    localparam int unsigned CONV_US = 40;
    localparam int unsigned CONV_CYC = CONV_US * CLK_MHZ;
    localparam int unsigned DWELL_US = 20;
    localparam int unsigned DWELL_CYC = DWELL_US * CLK_MHZ;

    // ----------------------------------------------------------------
    // Converter channels, threshold and key scan line count
    // ----------------------------------------------------------------
    localparam logic [7:0] BATTERY_SENSE_CHANNEL = 8'h01;
    localparam logic [7:0] ANALOG_IN_CHANNEL = 8'h00;
    localparam logic [7:0] BATT_LOW_THRESHOLD = 8'h80;
    localparam logic [3:0] KEY_LINES = 4'h9;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic power_switch;
        logic analog_trigger;
        logic adc_sdi;
        logic ga_sdata;
        logic [7:0] key_return_lines;
    } pin_in_t;

    typedef struct packed {
        logic adc_power;
        logic adc_mode;
        logic sck;
        logic sdo;
    } adc_pins_t;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_SETTLE = 7'b0000010,
        ST_FETCH = 7'b0000100,
        ST_SELECT = 7'b0001000,
        ST_CONVERT = 7'b0010000,
        ST_READ = 7'b0100000,
        ST_HOLD = 7'b1000000
    } seq_state_t;

endpackage : adc_seq_pkg

//--- rtl/serial_shifter.sv
// Eight-bit shift engine driving a negative-going shift clock
`timescale 1ns/1ps
module serial_shifter (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Request
    input wire logic start,
    input wire logic [7:0] tx_byte,
    input wire logic sdi,
    // Answer
    output logic busy,
    output logic done,
    output logic [7:0] rx_byte,
    // Serial pins
    output logic sck,
    output logic sdo
);
    logic busy_q, busy_d, done_q, done_d, sck_q, sck_d, sdo_q, sdo_d;
    logic [7:0] sh_q, sh_d;
    logic [2:0] bit_q, bit_d;
    logic [15:0] ph_q, ph_d;
    logic half_end;

    assign busy = busy_q;
    assign done = done_q;
    assign rx_byte = sh_q;
    assign sck = sck_q;
    assign sdo = sdo_q;
    assign half_end = (ph_q == 16'(adc_seq_pkg::SCK_HALF_CYC - 1));

    // ----------------------------------------------------------------
    // Shift sequence
    // ----------------------------------------------------------------
    always_comb begin
        busy_d = busy_q;
        done_d = 1'b0;
        sck_d = sck_q;
        sdo_d = sdo_q;
        sh_d = sh_q;
        bit_d = bit_q;
        ph_d = half_end ? 16'h0000 : ph_q + 16'h0001;
        if (!busy_q) begin
            ph_d = 16'h0000;
            if (start) begin
                busy_d = 1'b1;
                sh_d = tx_byte;
                sdo_d = tx_byte[7];
                sck_d = 1'b0;
                bit_d = 3'h0;
            end
        end else if (half_end) begin
            if (!sck_q) begin
                sck_d = 1'b1;
                sh_d = {sh_q[6:0], sdi};
            end else if (bit_q == 3'h7) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end else begin
                sck_d = 1'b0;
                sdo_d = sh_q[7];
                bit_d = bit_q + 3'h1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            busy_q <= 1'b0;
            done_q <= 1'b0;
            sck_q <= 1'b1;
            sdo_q <= 1'b1;
            sh_q <= 8'h00;
            bit_q <= 3'h0;
            ph_q <= 16'h0000;
        end else begin
            busy_q <= busy_d;
            done_q <= done_d;
            sck_q <= sck_d;
            sdo_q <= sdo_d;
            sh_q <= sh_d;
            bit_q <= bit_d;
            ph_q <= ph_d;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [3:0] falls_q;
    always_ff @(posedge clk) begin
        if (!reset_n || (start && !busy_q)) begin
            falls_q <= 4'h0;
        end else if ($fell(sck_q)) begin
            falls_q <= falls_q + 4'h1;
        end
    end

    property p_eight_clocks;
        @(posedge clk) disable iff (!reset_n) done_q |-> (falls_q == 4'h8);
    endproperty
    a_eight_clocks: assert property (p_eight_clocks)
        else $error("shift byte did not use eight clocks");

    property p_msb_first;
        @(posedge clk) disable iff (!reset_n)
            (start && !busy_q) |=> (sdo_q == $past(tx_byte[7])) && !sck_q;
    endproperty
    a_msb_first: assert property (p_msb_first)
        else $error("first bit out is not the msb");

endmodule : serial_shifter

//--- rtl/key_scanner.sv
// Keyboard matrix scanner with start-up DIP switch read
`timescale 1ns/1ps
module key_scanner (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Control
    input wire logic enable,
    input wire logic init,
    input wire logic [7:0] key_return_lines,
    // Scan pins
    output logic [8:0] key_scan_lines,
    output logic switch_scan_line,
    // Results
    output logic [6:0] dip_switches,
    output logic key_event,
    output logic [3:0] key_line,
    output logic [7:0] key_bits
);
    logic [3:0] idx_q, idx_d;
    logic [15:0] dw_q, dw_d;
    logic sw_q, sw_d, ev_q, ev_d, sample;
    logic [6:0] dip_q, dip_d;
    logic [7:0] bits_q, bits_d;
    logic [8:0] lines_q, lines_d;

    assign key_scan_lines = lines_q;
    assign switch_scan_line = sw_q;
    assign dip_switches = dip_q;
    assign key_event = ev_q;
    assign key_line = idx_q;
    assign key_bits = bits_q;
    assign sample = (dw_q == 16'(adc_seq_pkg::DWELL_CYC - 1));

    always_comb begin
        idx_d = idx_q;
        sw_d = sw_q;
        dip_d = dip_q;
        bits_d = bits_q;
        ev_d = 1'b0;
        lines_d = 9'h000;
        dw_d = sample ? 16'h0000 : dw_q + 16'h0001;
        if (init) begin
            sw_d = 1'b1;
            dw_d = 16'h0000;
        end else if (sw_q) begin
            if (sample) begin
                dip_d = key_return_lines[7:1];
                sw_d = 1'b0;
                idx_d = 4'h0;
            end
        end else if (enable) begin
            lines_d = 9'(9'h001 << idx_q);
            if (sample) begin
                bits_d = key_return_lines;
                ev_d = (key_return_lines != 8'h00);
                idx_d = (idx_q == adc_seq_pkg::KEY_LINES - 4'h1) ? 4'h0 : idx_q + 4'h1;
                lines_d = 9'h000;
            end
        end else begin
            dw_d = 16'h0000;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            idx_q <= 4'h0;
            dw_q <= 16'h0000;
            sw_q <= 1'b0;
            ev_q <= 1'b0;
            dip_q <= 7'h00;
            bits_q <= 8'h00;
            lines_q <= 9'h000;
        end else begin
            idx_q <= idx_d;
            dw_q <= dw_d;
            sw_q <= sw_d;
            ev_q <= ev_d;
            dip_q <= dip_d;
            bits_q <= bits_d;
            lines_q <= lines_d;
        end
    end

    property p_one_line;
        @(posedge clk) disable iff (!reset_n)
            $onehot0({lines_q, sw_q}) && !(sw_q && enable && lines_q != 9'h000);
    endproperty
    a_one_line: assert property (p_one_line)
        else $error("more than one scan line driven");

endmodule : key_scanner

//--- tb/adc_partner.sv
// Behavioural serial converter model
`timescale 1ns/1ps
module adc_partner (
    // Converter pins
    input wire logic power,
    input wire logic mode,
    input wire logic sck,
    input wire logic din,
    // Levels to convert
    input wire logic [7:0] batt_level,
    input wire logic [7:0] analog_level,
    // Answer
    output logic dout,
    output logic [7:0] channel
);
    logic [7:0] sr = 8'h00;
    logic conv = 1'b0;
    initial dout = 1'b1;
    initial channel = 8'h00;
    always @(posedge sck) begin
        if (power && !mode) begin
            sr <= {sr[6:0], din};
        end
    end
    always @(negedge sck or negedge mode) begin
        if (power && !mode && conv) begin
            dout <= sr[7];
        end
    end
    // convert on mode rise, hold result
    always @(posedge mode or negedge power) begin
        dout <= ~dout;
        if (power) begin
            if (!conv) begin
                channel <= sr;
                sr <= (sr == 8'h01) ? batt_level : analog_level;
            end
            conv <= !conv;
        end else begin
            conv <= 1'b0;
        end
    end
endmodule : adc_partner

//--- tb/battery_monitor_adc_sequencer_bench.sv
// Self-checking bench for the sequencer
`timescale 1ns/1ps
module battery_monitor_adc_sequencer_bench;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic power_switch = 1'b0;
    logic analog_trigger = 1'b0;
    logic ga_sdata = 1'b0;
    logic [7:0] rets = 8'h00;
    logic [7:0] batt = 8'h00;
    logic [7:0] ana = 8'h00;
    logic sdi, system_on, req, backup, irq, valid, key_event, sws;
    logic [8:0] scan;
    logic [7:0] channel, bval, aval, key_bits;
    logic [6:0] dips;
    adc_seq_pkg::adc_pins_t pins;
    int err_count = 0;
    int checked = 0;
    int n;
    always #10 clk = ~clk;
    always @(posedge clk) #1 ga_sdata = 1'($urandom());
    battery_monitor_adc_sequencer #(.CHECK_CYC(20000), .POWER_CYC(8000))
        battery_monitor_adc_sequencer_i (.clk(clk), .reset_n(reset_n),
        .power_switch(power_switch), .shutdown_req(1'b0), .analog_trigger(analog_trigger),
        .adc_sdi(sdi), .ga_sdata(ga_sdata), .key_return_lines(rets), .adc_pins(pins),
        .key_scan_lines(scan), .switch_scan_line(sws), .system_on(system_on), .power_on_req(req),
        .batt_backup(backup), .low_volt_irq(irq), .battery_value(bval),
        .analog_value(aval), .analog_valid(valid), .ga_command(), .dip_switches(dips),
        .key_event(key_event), .key_line(), .key_bits(key_bits));
    adc_partner adc_partner_i (.power(pins.adc_power), .mode(pins.adc_mode),
        .sck(pins.sck), .din(pins.sdo), .batt_level(batt), .analog_level(ana),
        .dout(sdi), .channel(channel));
    // ----------------
    // Shared tasks
    // ----------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic test_done;
        $display("checks=%0d errors=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    // Bounded wait; a hang counts as a mismatch
    task automatic wait_for(input int sel, input logic v, input int lim);
        logic s;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
            case (sel)
                0: s = pins.adc_power;
                1: s = req;
                2: s = valid;
                default: s = key_event;
            endcase
        end while (s !== v && n < lim);
        if (s !== v) begin
            err_count++;
            test_done();
        end
    endtask : wait_for
    task automatic batt_check(input logic [7:0] lvl);
        int low;
        batt = lvl;
        low = (int'(lvl) < 128);
        // A window left open by an earlier job must close before timing a new one
        wait_for(0, 1'b0, 9000);
        wait_for(0, 1'b1, 25000);
        wait_for(0, 1'b0, 9000);
        check(n, 8000);
        check(channel, 8'h01);
        check(bval, lvl);
        check(backup, low);
        check(irq, low & system_on);
    endtask : batt_check
    // ----------------
    // Main sequence
    // ----------------
    initial begin
        void'($urandom(32'hC87C0BB5));
        rets = 8'($urandom()) | 8'h01;
        repeat (3) @(posedge clk);
        #1 reset_n = 1'b1;
        check(pins, 4'b0111);
        batt_check(8'h7F);
        batt_check(8'h80);
        batt_check(8'($urandom()));
        power_switch = 1'b1;
        wait_for(1, 1'b1, 10);
        check(system_on, 1'b1);
        ana = 8'($urandom());
        analog_trigger = 1'b1;
        wait_for(2, 1'b1, 10000);
        analog_trigger = 1'b0;
        check(aval, ana);
        check(channel, 8'h00);
        check(dips, rets[7:1]);
        wait_for(3, 1'b1, 3000);
        check(key_bits, rets);
        @(posedge clk);
        #1;
        check($countones(scan), 1);
        check(sws, 1'b0);
        batt_check(8'h10);
        test_done();
    end
endmodule : battery_monitor_adc_sequencer_bench
